//--- rtl/jcm_pkg.sv
/*
   Constants for the coefficient coding model: the zigzag order, the default
   step tables, the symbol codes and the state types.
   Assumes 8-bit samples, so quantized coefficients fit 12 bits signed.
*/
package jcm_pkg;

   localparam int CW = 12;          // coefficient width
   localparam int NCOMP = 4;        // colour components per image
   localparam int NCOEF = 64;       // coefficients per block
   localparam int FW = 45;          // fifo word: sym, code, code len, bits, size
   localparam int FDEPTH = 4;
   localparam logic [7:0] SYM_EOB = 8'h00;
   localparam logic [7:0] SYM_ZRL = 8'hf0;
   localparam logic [5:0] POS_LAST = 6'h3f;
   localparam logic [5:0] RUN_MAX = 6'h0f;
   localparam logic [5:0] RUN_SKIP = 6'h10;

   // raster position -> scan position
   localparam logic [5:0] ZZ [NCOEF] = '{
       0,  1,  5,  6, 14, 15, 27, 28,  2,  4,  7, 13, 16, 26, 29, 42,
       3,  8, 12, 17, 25, 30, 41, 43,  9, 11, 18, 24, 31, 40, 44, 53,
      10, 19, 23, 32, 39, 45, 52, 54, 20, 22, 33, 38, 46, 51, 55, 60,
      21, 34, 37, 47, 50, 56, 59, 61, 35, 36, 48, 49, 57, 58, 62, 63};

   // default luminance steps, raster order
   localparam logic [7:0] Q_LUMA [NCOEF] = '{
      16, 11, 10, 16, 24, 40, 51, 61, 12, 12, 14, 19, 26, 58, 60, 55,
      14, 13, 16, 24, 40, 57, 69, 56, 14, 17, 22, 29, 51, 87, 80, 62,
      18, 22, 37, 58, 68,109,103, 77, 24, 35, 55, 64, 81,104,113, 92,
      49, 64, 78, 87,103,121,120,101, 72, 92, 95, 98,112,100,103, 99};

   // default chrominance steps, raster order
   localparam logic [7:0] Q_CHROMA [NCOEF] = '{
      17, 18, 24, 47, 99, 99, 99, 99, 18, 21, 26, 66, 99, 99, 99, 99,
      24, 26, 56, 99, 99, 99, 99, 99, 47, 66, 99, 99, 99, 99, 99, 99,
      99, 99, 99, 99, 99, 99, 99, 99, 99, 99, 99, 99, 99, 99, 99, 99,
      99, 99, 99, 99, 99, 99, 99, 99, 99, 99, 99, 99, 99, 99, 99, 99};

   typedef enum logic [1:0] {E_LOAD, E_DC, E_AC, E_EOB} jcm_enc_e;

   // step for a raster position; component 0 is luminance
   function automatic logic [7:0] jcm_step(input logic chroma, input logic [5:0] r);
      return chroma ? Q_CHROMA[r] : Q_LUMA[r];
   endfunction : jcm_step

   // scan position -> raster position
   function automatic logic [5:0] jcm_raster(input logic [5:0] p);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 0; i < NCOEF; i++) begin
         if (ZZ[i] == p) r = 6'(i);
      end
      return r;
   endfunction : jcm_raster

   // number of significant bits of a signed value
   function automatic logic [3:0] jcm_size(input logic signed [CW:0] v);
      logic [CW:0] m;
      logic [3:0]  s;
      m = v[CW] ? 13'(-v) : 13'(v);
      s = 4'h0;
      for (int i = 0; i < CW; i++) begin
         if (m[i]) s = 4'(i + 1);
      end
      return s;
   endfunction : jcm_size

endpackage : jcm_pkg

//--- rtl/jcm_fifo.sv
/*
   Small shift fifo; the head entry and its valid are flip-flops, so the
   drain side sees registered outputs. Assumes one clock and a drain that
   may stall at will.
*/
`timescale 1ns/10ps
module jcm_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);

   logic [W-1:0] data_q [D];
   logic [W-1:0] data_d [D];
   logic [D-1:0] vld_q;
   logic [D-1:0] vld_d;
   logic [D-1:0] sv;
   logic         pop;
   logic         push;

   // handshakes; full stalls the source
   assign pop       = vld_q[0] & out_ready;
   assign in_ready  = ~vld_q[D-1];
   assign push      = in_valid & in_ready;
   assign out_valid = vld_q[0];
   assign out_data  = data_q[0];

   // per entry: shift on pop, then fill the first empty slot
   for (genvar i = 0; i < D; i++) begin : g_ent
      if (i == D - 1) begin : g_top
         assign sv[i] = pop ? 1'b0 : vld_q[i];
      end else begin : g_mid
         assign sv[i] = pop ? vld_q[i+1] : vld_q[i];
      end
      always_comb begin
         data_d[i] = data_q[i];
         if (pop && i < D - 1) data_d[i] = data_q[(i < D - 1) ? i + 1 : i];
         vld_d[i] = sv[i];
         if (push && !sv[i] && (i == 0 || sv[(i > 0) ? i - 1 : 0])) begin
            data_d[i] = in_data;
            vld_d[i]  = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         vld_q  <= '0;
         data_q <= '{default: '0};
      end else begin
         vld_q  <= vld_d;
         data_q <= data_d;
      end
   end

endmodule : jcm_fifo

//--- rtl/jcm_coding_model.sv
/*
   Coefficient coding model: quantizer, zigzag, DC prediction, run/size
   symbols with table lookup (encoder) and the inverse path (decoder).
   Assumes coefficients arrive in raster order from a transform stage on
   the same clock, and that the decoder's consumer takes one per cycle.
*/
// Notes on behaviour
// - each coefficient is divided by a step chosen by position and component.
// - quantized blocks are reordered through the fixed 64-entry zigzag table.
// - the encoder emits the DC difference to the previous block of the same component, never the raw DC.
// - the decoder rebuilds DC as received difference plus previous reconstructed DC.
// - an AC symbol's high nibble counts zeros before the next nonzero coefficient.
// - an AC symbol's low nibble is the bit count of that nonzero coefficient.
// - exactly that many significant bits follow each symbol.
// - the decoder first appends as many zeros as the symbol's run field says.
// - the decoder then appends one coefficient rebuilt from size and trailing bits.
// - symbols map to variable-length codes through a lookup table.
// - tables are preloaded, so coding runs in one pass without statistics.
// - the loaded tables give frequent symbols short codes and rare ones long codes.
// - up to four components, each with samples of at most eight bits.
// - work is done in blocks of 8 by 8.
// - blocks of different components may interleave; each keeps its own predictor.
// - position 0 is DC, the other 63 are AC in zigzag order.
`timescale 1ns/10ps
module jcm_coding_model
   import jcm_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic                 frame_start,
   input  wire logic                 tab_we,
   input  wire logic [9:0]           tab_addr,
   input  wire logic [15:0]          tab_code,
   input  wire logic [4:0]           tab_len,
   input  wire logic                 enc_in_valid,
   output logic                      enc_in_ready,
   input  wire logic signed [CW-1:0] enc_in_coef,
   input  wire logic [1:0]           enc_in_comp,
   output logic                      enc_out_valid,
   input  wire logic                 enc_out_ready,
   output logic [7:0]                enc_out_sym,
   output logic [15:0]               enc_out_code,
   output logic [4:0]                enc_out_code_len,
   output logic [CW-1:0]             enc_out_bits,
   output logic [3:0]                enc_out_bits_len,
   input  wire logic                 dec_in_valid,
   output logic                      dec_in_ready,
   input  wire logic                 dec_in_dc,
   input  wire logic [7:0]           dec_in_sym,
   input  wire logic [CW-1:0]        dec_in_bits,
   input  wire logic [1:0]           dec_in_comp,
   output logic                      dec_out_valid,
   output logic signed [19:0]        dec_out_coef,
   output logic [5:0]                dec_out_pos,
   output logic                      dec_out_last
);

   // ---------------- encoder state
   jcm_enc_e                st_q, st_d;
   logic [5:0]              idx_q, idx_d, pos_q, pos_d, run_q, run_d;
   logic [1:0]              comp_q, comp_d;
   logic signed [CW-1:0]    blk_q [NCOEF];
   logic signed [CW-1:0]    blk_d [NCOEF];
   logic signed [CW-1:0]    epred_q [NCOMP];
   logic signed [CW-1:0]    epred_d [NCOMP];
   logic                    enc_ready_q, enc_ready_d;
   logic signed [CW-1:0]    quot, cur;
   logic signed [CW:0]      diff;
   logic [7:0]              sym;
   logic [3:0]              sz;
   logic [CW-1:0]           ebits, tmp;
   logic                    push, f_ready;
   logic [9:0]              hidx;
   logic [15:0]             huf_code [1024];
   logic [4:0]              huf_len [1024];
   logic [FW-1:0]           f_out;

   // quantize on entry: coefficient over position step
   assign quot = enc_in_coef / $signed({4'h0, jcm_step(enc_in_comp != 2'h0, idx_q)});

   // encoder: load, DC difference, AC run/size scan, end of block
   always_comb begin
      st_d    = st_q;
      idx_d   = idx_q;
      pos_d   = pos_q;
      run_d   = run_q;
      comp_d  = comp_q;
      blk_d   = blk_q;
      epred_d = epred_q;
      push    = 1'b0;
      sym     = SYM_EOB;
      diff    = '0;
      cur     = blk_q[pos_q];
      unique case (st_q)
         E_LOAD: if (enc_in_valid && enc_ready_q) begin
            blk_d[ZZ[idx_q]] = quot;
            if (idx_q == 6'h00) comp_d = enc_in_comp;
            idx_d = idx_q + 6'h01;
            if (idx_q == POS_LAST) st_d = E_DC;
         end
         E_DC: begin
            diff = {blk_q[0][CW-1], blk_q[0]} - {epred_q[comp_q][CW-1], epred_q[comp_q]};
            push = 1'b1;
            sym  = {4'h0, jcm_size(diff)};
            if (f_ready) begin
               epred_d[comp_q] = blk_q[0];
               pos_d = 6'h01;
               run_d = 6'h00;
               st_d  = E_AC;
            end
         end
         E_AC: begin
            if (cur == '0) begin
               run_d = run_q + 6'h01;
               if (pos_q == POS_LAST) st_d = E_EOB;
               else pos_d = pos_q + 6'h01;
            end else if (run_q > RUN_MAX) begin
               push = 1'b1;
               sym  = SYM_ZRL;
               if (f_ready) run_d = run_q - RUN_SKIP;
            end else begin
               diff = {cur[CW-1], cur};
               push = 1'b1;
               sym  = {run_q[3:0], jcm_size(diff)};
               if (f_ready) begin
                  run_d = 6'h00;
                  if (pos_q == POS_LAST) st_d = E_EOB;
                  else pos_d = pos_q + 6'h01;
               end
            end
         end
         E_EOB: begin
            push = (run_q != 6'h00);
            if (f_ready || run_q == 6'h00) st_d = E_LOAD;
         end
      endcase
      if (frame_start) epred_d = '{default: '0};
      enc_ready_d = (st_d == E_LOAD);
   end

   // significant bits: negative values are sent as value minus one
   always_comb begin
      sz    = sym[3:0];
      tmp   = diff[CW] ? 12'(diff - 13'sh1) : diff[CW-1:0];
      ebits = tmp & (12'hfff >> (4'hc - sz));
   end

   // code lookup: {chroma, ac, symbol}
   assign hidx = {comp_q != 2'h0, st_q != E_DC, sym};

   always_ff @(posedge clk) begin
      if (tab_we) begin
         huf_code[tab_addr] <= tab_code;
         huf_len[tab_addr]  <= tab_len;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q        <= E_LOAD;
         idx_q       <= 6'h00;
         pos_q       <= 6'h00;
         run_q       <= 6'h00;
         comp_q      <= 2'h0;
         blk_q       <= '{default: '0};
         epred_q     <= '{default: '0};
         enc_ready_q <= 1'b0;
      end else begin
         st_q        <= st_d;
         idx_q       <= idx_d;
         pos_q       <= pos_d;
         run_q       <= run_d;
         comp_q      <= comp_d;
         blk_q       <= blk_d;
         epred_q     <= epred_d;
         enc_ready_q <= enc_ready_d;
      end
   end

   assign enc_in_ready = enc_ready_q;

   jcm_fifo #(.W(FW), .D(FDEPTH)) u_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (push),
      .in_ready  (f_ready),
      .in_data   ({sym, huf_code[hidx], huf_len[hidx], ebits, sz}),
      .out_valid (enc_out_valid),
      .out_ready (enc_out_ready),
      .out_data  (f_out)
   );

   // symbol word fields from the fifo head
   assign enc_out_sym      = f_out[44:37];
   assign enc_out_code     = f_out[36:21];
   assign enc_out_code_len = f_out[20:16];
   assign enc_out_bits     = f_out[15:4];
   assign enc_out_bits_len = f_out[3:0];

   // ---------------- decoder state
   logic [5:0]              dscan_q, dscan_d;
   logic [3:0]              zrun_q, zrun_d;
   logic                    pend_q, pend_d, fill_q, fill_d;
   logic signed [CW-1:0]    pval_q, pval_d;
   logic signed [CW-1:0]    dpred_q [NCOMP];
   logic signed [CW-1:0]    dpred_d [NCOMP];
   logic [1:0]              dcomp_q, dcomp_d, ucomp;
   logic                    drdy_q, drdy_d, dov_q, dov_d, dlast_q, dlast_d;
   logic signed [19:0]      dcoef_q, dcoef_d;
   logic [5:0]              draster_q, draster_d;
   logic                    take, ov;
   logic signed [CW-1:0]    oval, dext;
   logic [CW-1:0]           dmask, dm;
   logic signed [20:0]      prod;

   // rebuild a value from its size and trailing bits
   always_comb begin
      dmask = 12'hfff >> (4'hc - dec_in_sym[3:0]);
      dm    = dec_in_bits & dmask;
      if (dec_in_sym[3:0] == 4'h0) dext = '0;
      else if ((dm & ~(dmask >> 1)) != '0) dext = dm;
      else dext = dm - dmask;
   end

   // decoder: zeros of the run, then the coefficient, one per cycle
   always_comb begin
      dscan_d = dscan_q;
      zrun_d  = zrun_q;
      pend_d  = pend_q;
      fill_d  = fill_q;
      pval_d  = pval_q;
      dpred_d = dpred_q;
      dcomp_d = dcomp_q;
      ov      = 1'b0;
      oval    = '0;
      take    = dec_in_valid && drdy_q;
      ucomp   = dcomp_q;
      if (fill_q) begin
         ov = 1'b1;
      end else if (zrun_q != 4'h0) begin
         ov     = 1'b1;
         zrun_d = zrun_q - 4'h1;
      end else if (pend_q) begin
         ov     = 1'b1;
         oval   = pval_q;
         pend_d = 1'b0;
      end else if (take) begin
         if (dec_in_dc) begin
            oval  = dpred_q[dec_in_comp] + dext;
            ov    = 1'b1;
            ucomp = dec_in_comp;
            dpred_d[dec_in_comp] = oval;
            dcomp_d = dec_in_comp;
         end else if (dec_in_sym == SYM_EOB) begin
            fill_d = 1'b1;
         end else begin
            zrun_d = dec_in_sym[7:4];
            pend_d = 1'b1;
            pval_d = dext;
         end
      end
      if (ov) begin
         dscan_d = dscan_q + 6'h01;
         if (dscan_q == POS_LAST) fill_d = 1'b0;
      end
      if (frame_start) dpred_d = '{default: '0};
      drdy_d    = !fill_d && zrun_d == 4'h0 && !pend_d;
      dov_d     = ov;
      dlast_d   = ov && dscan_q == POS_LAST;
      draster_d = jcm_raster(dscan_q);
      prod      = oval * $signed({1'b0, jcm_step(ucomp != 2'h0, draster_d)});
      dcoef_d   = prod[19:0];
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dscan_q   <= 6'h00;
         zrun_q    <= 4'h0;
         pend_q    <= 1'b0;
         fill_q    <= 1'b0;
         pval_q    <= '0;
         dpred_q   <= '{default: '0};
         dcomp_q   <= 2'h0;
         drdy_q    <= 1'b0;
         dov_q     <= 1'b0;
         dlast_q   <= 1'b0;
         dcoef_q   <= '0;
         draster_q <= 6'h00;
      end else begin
         dscan_q   <= dscan_d;
         zrun_q    <= zrun_d;
         pend_q    <= pend_d;
         fill_q    <= fill_d;
         pval_q    <= pval_d;
         dpred_q   <= dpred_d;
         dcomp_q   <= dcomp_d;
         drdy_q    <= drdy_d;
         dov_q     <= dov_d;
         dlast_q   <= dlast_d;
         dcoef_q   <= dcoef_d;
         draster_q <= draster_d;
      end
   end

   assign dec_in_ready  = drdy_q;
   assign dec_out_valid = dov_q;
   assign dec_out_coef  = dcoef_q;
   assign dec_out_pos   = draster_q;
   assign dec_out_last  = dlast_q;

   // ---------------- checks
   a_load_block: assert property (@(posedge clk) disable iff (!resetn)
      (st_q == E_LOAD && enc_in_valid && enc_ready_q && idx_q == POS_LAST)
      |=> (st_q == E_DC && !enc_ready_q))
      else $error("block not closed after 64 coefficients");
   a_dc_symbol: assert property (@(posedge clk) disable iff (!resetn)
      (st_q == E_DC) |-> (sym[7:4] == 4'h0 && sz == jcm_size(diff)))
      else $error("dc symbol malformed");
   a_dc_pred: assert property (@(posedge clk) disable iff (!resetn)
      (st_q == E_DC && f_ready && !frame_start)
      |=> (epred_q[comp_q] == blk_q[0] && st_q == E_AC && pos_q == 6'h01))
      else $error("dc predictor not updated");
   a_ac_size: assert property (@(posedge clk) disable iff (!resetn)
      (st_q == E_AC && push && sym != SYM_ZRL) |-> (sz != 4'h0 && sz == jcm_size({cur[CW-1], cur})))
      else $error("ac size nibble wrong");
   a_zero_run: assert property (@(posedge clk) disable iff (!resetn)
      (st_q == E_AC && cur == '0) |=> (run_q == $past(run_q) + 6'h01))
      else $error("zero run not counted");
   a_bits_len: assert property (@(posedge clk) disable iff (!resetn)
      push |-> ((ebits >> sz) == '0 && sz == sym[3:0]))
      else $error("bit count differs from size");
   a_dec_zeros: assert property (@(posedge clk) disable iff (!resetn)
      (take && !dec_in_dc && dec_in_sym[7:4] == 4'h2 && !fill_q && zrun_q == 4'h0 && !pend_q)
      |=> ##1 (dov_q && dcoef_q == '0) ##1 (dov_q && dcoef_q == '0) ##1 dov_q)
      else $error("run zeros not emitted");
   a_dec_dc: assert property (@(posedge clk) disable iff (!resetn)
      (take && dec_in_dc && !fill_q && zrun_q == 4'h0 && !pend_q)
      |=> (dov_q && draster_q == 6'h00))
      else $error("dc not placed at position 0");
   a_pred_clear: assert property (@(posedge clk) disable iff (!resetn)
      frame_start |=> (epred_q[0] == '0 && dpred_q[3] == '0))
      else $error("predictors not cleared at frame start");

endmodule : jcm_coding_model

//--- dv/jcm_sink_model.sv
/*
   Stand-in for the entropy coder behind the encoder output: takes words
   at full rate, or once in eight cycles when slow so the fifo backs up.
   Assumes one clock shared with the coding model.
*/
`timescale 1ns/10ps
module jcm_sink_model (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic slow,
   output logic      ready
);
   logic [2:0] cnt_q;
   logic [2:0] cnt_d;

   // stall counter, ready only at its wrap when slow
   always_comb begin
      cnt_d = cnt_q + 3'h1;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 3'h0;
         ready <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         ready <= !slow || (cnt_q == 3'h7);
      end
   end
endmodule : jcm_sink_model

//--- dv/jcm_coding_model_bench.sv
/*
   Self-checking bench for the coding model: encoder blocks with expected
   symbol words, decoder symbols with expected coefficients.
   Assumes code table entry = address mixed with a fixed pattern.
*/
`timescale 1ns/10ps
module jcm_coding_model_bench
   import jcm_pkg::*;
   ;
   logic clk, resetn, frame_start, tab_we, slow;
   logic [9:0] tab_addr;
   logic [15:0] tab_code;
   logic [4:0] tab_len, enc_out_code_len;
   logic enc_in_valid, enc_in_ready, enc_out_valid, enc_out_ready;
   logic signed [CW-1:0] enc_in_coef;
   logic [1:0] enc_in_comp, dec_in_comp;
   logic [7:0] enc_out_sym, dec_in_sym;
   logic [15:0] enc_out_code;
   logic [CW-1:0] enc_out_bits, dec_in_bits;
   logic [3:0] enc_out_bits_len;
   logic dec_in_valid, dec_in_ready, dec_in_dc, dec_out_valid, dec_out_last;
   logic signed [19:0] dec_out_coef;
   logic [5:0] dec_out_pos;
   logic signed [CW-1:0] blk [NCOEF];
   logic signed [19:0] dout [NCOEF];
   logic [44:0] expq [$];
   logic [44:0] gotq [$];
   int err_total, n_tests, dcnt, dlast, cyc;

   jcm_coding_model i_jcm_coding_model (
      .clk, .resetn, .frame_start, .tab_we, .tab_addr, .tab_code, .tab_len,
      .enc_in_valid, .enc_in_ready, .enc_in_coef, .enc_in_comp,
      .enc_out_valid, .enc_out_ready, .enc_out_sym, .enc_out_code,
      .enc_out_code_len, .enc_out_bits, .enc_out_bits_len,
      .dec_in_valid, .dec_in_ready, .dec_in_dc, .dec_in_sym, .dec_in_bits,
      .dec_in_comp, .dec_out_valid, .dec_out_coef, .dec_out_pos, .dec_out_last);

   jcm_sink_model i_jcm_sink_model (.clk, .resetn, .slow, .ready(enc_out_ready));

   // clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // capture encoder takes and decoder outputs
   always @(posedge clk) begin
      if (resetn && enc_out_valid && enc_out_ready)
         gotq.push_back({enc_out_sym, enc_out_code, enc_out_code_len,
                         enc_out_bits, enc_out_bits_len});
      if (resetn && dec_out_valid) begin
         dout[dec_out_pos] = dec_out_coef;
         dcnt++;
         if (dec_out_last) dlast++;
      end
   end

   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         summarize();
      end
   end

   function automatic logic [44:0] word(logic c, logic ac, logic [7:0] s,
                                        logic [11:0] b, logic [3:0] n);
      logic [9:0] a;
      a = {c, ac, s};
      return {s, 16'(a) ^ 16'h0a5c, {1'b0, a[3:0]} + 5'h1, b, n};
   endfunction : word

   task automatic check(input logic [44:0] seen, input logic [44:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   // code table preload, one entry per cycle
   task automatic tabload();
      for (int i = 0; i < 1024; i++) begin
         tab_addr = 10'(i);
         {tab_code, tab_len} = 21'(word(tab_addr[9], tab_addr[8], tab_addr[7:0],
                                        12'h000, 4'h0) >> 16);
         tab_we = 1'b1;
         @(posedge clk);
         #1;
      end
      tab_we = 1'b0;
   endtask : tabload

   // one block of 64 coefficients, raster order
   task automatic eblk(input logic [1:0] comp);
      enc_in_comp = comp;
      for (int i = 0; i < NCOEF; i++) begin
         enc_in_coef = blk[i];
         enc_in_valid = 1'b1;
         while (!enc_in_ready) begin
            @(posedge clk);
            #1;
         end
         @(posedge clk);
         #1;
      end
      enc_in_valid = 1'b0;
      foreach (blk[i]) blk[i] = 12'h000;
      @(posedge clk);
      #1;
   endtask : eblk

   task automatic drain();
      int k;
      k = 0;
      while ((gotq.size() < expq.size() || !enc_in_ready) && k < 3000) begin
         @(posedge clk);
         k++;
      end
      repeat (4) @(posedge clk);
      #1;
      check(45'(gotq.size()), 45'(expq.size()));
      foreach (expq[i]) check(gotq[i], expq[i]);
      expq.delete();
      gotq.delete();
   endtask : drain

   task automatic dsend(input logic dc, input logic [7:0] s, input logic [11:0] b);
      dec_in_dc = dc;
      dec_in_sym = s;
      dec_in_bits = b;
      dec_in_valid = 1'b1;
      while (!dec_in_ready) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      #1;
      dec_in_valid = 1'b0;
      @(posedge clk);
      #1;
   endtask : dsend

   // dc difference, truncating steps, single ac then end of block
   task automatic t_enc_basic();
      blk[0] = 12'sd87;
      blk[1] = -12'sd35;
      eblk(2'h0);
      expq.push_back(word(0, 0, 8'h03, 12'h005, 4'h3));
      expq.push_back(word(0, 1, 8'h02, 12'h000, 4'h2));
      expq.push_back(word(0, 1, 8'h00, 12'h000, 4'h0));
      drain();
   endtask : t_enc_basic

   // long zero runs across the zigzag, consumer stalling
   task automatic t_enc_runs();
      slow = 1'b1;
      blk[0] = 12'sd40;
      blk[40] = 12'sd49;
      blk[63] = -12'sd149;
      eblk(2'h0);
      expq.push_back(word(0, 0, 8'h02, 12'h000, 4'h2));
      expq.push_back(word(0, 1, 8'hf0, 12'h000, 4'h0));
      expq.push_back(word(0, 1, 8'h32, 12'h002, 4'h2));
      expq.push_back(word(0, 1, 8'hf0, 12'h000, 4'h0));
      expq.push_back(word(0, 1, 8'hf0, 12'h000, 4'h0));
      expq.push_back(word(0, 1, 8'ha1, 12'h000, 4'h1));
      drain();
      slow = 1'b0;
   endtask : t_enc_runs

   // chroma block between luma blocks, separate predictors
   task automatic t_enc_chroma();
      blk[0] = 12'sd70;
      blk[63] = 12'sd248;
      eblk(2'h2);
      expq.push_back(word(1, 0, 8'h03, 12'h004, 4'h3));
      expq.push_back(word(1, 1, 8'hf0, 12'h000, 4'h0));
      expq.push_back(word(1, 1, 8'hf0, 12'h000, 4'h0));
      expq.push_back(word(1, 1, 8'hf0, 12'h000, 4'h0));
      expq.push_back(word(1, 1, 8'he2, 12'h002, 4'h2));
      eblk(2'h0);
      expq.push_back(word(0, 0, 8'h02, 12'h001, 4'h2));
      expq.push_back(word(0, 1, 8'h00, 12'h000, 4'h0));
      drain();
   endtask : t_enc_chroma

   // frame start clears the predictor
   task automatic t_frame();
      frame_start = 1'b1;
      @(posedge clk);
      #1;
      frame_start = 1'b0;
      blk[0] = 12'sd34;
      eblk(2'h2);
      expq.push_back(word(1, 0, 8'h02, 12'h002, 4'h2));
      expq.push_back(word(1, 1, 8'h00, 12'h000, 4'h0));
      drain();
   endtask : t_frame

   // decoder: dc rebuild, zero run, coefficient, fill to end
   task automatic t_dec();
      dcnt = 0;
      dsend(1'b1, 8'h03, 12'h005);
      dsend(1'b0, 8'h22, 12'h002);
      dsend(1'b0, 8'h00, 12'h000);
      for (int k = 0; k < 400 && dcnt < 64; k++) @(posedge clk);
      #1;
      check(45'(dout[0]), 45'h50);
      check(45'(dout[1]) | 45'(dout[8]), 45'h0);
      check(45'(dout[16]), 45'h1c);
      check(45'(dcnt), 45'h40);
      check(45'(dlast), 45'h1);
      dsend(1'b1, 8'h02, 12'h000);
      dsend(1'b0, 8'h00, 12'h000);
      repeat (80) @(posedge clk);
      #1;
      check(45'(dout[0]), 45'h20);
      dec_in_comp = 2'h1;
      dsend(1'b1, 8'h02, 12'h002);
      dsend(1'b0, 8'h00, 12'h000);
      repeat (80) @(posedge clk);
      #1;
      check(45'(dout[0]), 45'h22);
   endtask : t_dec

   // main sequence
   initial begin
      {resetn, frame_start, tab_we, slow, enc_in_valid, dec_in_valid} = '0;
      {tab_addr, tab_code, tab_len, enc_in_coef, enc_in_comp} = '0;
      {dec_in_dc, dec_in_sym, dec_in_bits, dec_in_comp} = '0;
      {err_total, n_tests, dcnt, dlast, cyc} = '0;
      foreach (blk[i]) blk[i] = 12'h000;
      repeat (6) @(posedge clk);
      check(45'({enc_in_ready, enc_out_valid, dec_out_valid}), 45'h0);
      #1;
      resetn = 1'b1;
      @(posedge clk);
      #1;
      check(45'(enc_in_ready), 45'h1);
      tabload();
      t_enc_basic();
      t_enc_runs();
      t_enc_chroma();
      t_frame();
      t_dec();
      summarize();
   end
endmodule : jcm_coding_model_bench
